// ---- verilog/ccrb_defs.vh ----
// Offsets, field positions, reset values and timing counts of the register bank.
`ifndef CCRB_DEFS_VH
`define CCRB_DEFS_VH
`define CCRB_OFS_POWER_PATH 8'h03
`define CCRB_OFS_CHG_CURRENT 8'h04
`define CCRB_OFS_PRE_TERM 8'h05
`define CCRB_OFS_CHG_VOLTAGE 8'h06
`define CCRB_BIT_LOAD_EN 7
`define CCRB_BIT_KICK 6
`define CCRB_BIT_BOOST_EN 5
`define CCRB_BIT_CHG_EN 4
`define CCRB_SYSMIN_HI 3
`define CCRB_SYSMIN_LO 1
`define CCRB_BIT_BOOST_EXIT 0
`define CCRB_BIT_PULSE_EN 7
`define CCRB_BIT_PRE_FAST 1
`define CCRB_BIT_RECHG 0
`define CCRB_RST_POWER_PATH 8'h3A
`define CCRB_RST_CHG_CURRENT 8'h20
`define CCRB_RST_PRE_TERM 8'h13
`define CCRB_RST_CHG_VOLTAGE 8'h82
`define CCRB_SYSMIN_RST 3'h5
`define CCRB_FAST_CHARGE_CURRENT_MAX 7'h4F
`define CCRB_CHARGE_VOLTAGE_LIMIT_MAX 6'h30
`define CCRB_WD_SEL_RST 2'h1
`define CCRB_WD_UNIT_S 40
`define CCRB_CLK_HZ 200000000
`define CCRB_TICK_CYCLES (`CCRB_CLK_HZ / 1000)
`define CCRB_WD_UNIT_MS (`CCRB_WD_UNIT_S * 1000)
`endif

// ---- verilog/ccrb_register_bank.v ----
// Charger configuration register bank with watchdog reset of its fields, except the minimum system voltage field, which it keeps.
`timescale 1ns/1ps
`include "ccrb_defs.vh"
module ccrb_register_bank #(
  parameter TICK_CYCLES = `CCRB_TICK_CYCLES,
  parameter WD_UNIT_MS = `CCRB_WD_UNIT_MS
) (
  input wire clk,
  input wire rst_n,
  input wire wr_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  input wire reg_reset,
  input wire [1:0] watchdog_period_sel,
  output reg watchdog_expired,
  output wire battery_load_enable,
  output wire boost_output_enable,
  output wire charge_enable,
  output wire charge_active,
  output wire [2:0] min_system_voltage,
  output wire boost_exit_select,
  output wire pulse_control_enable,
  output wire [6:0] fast_charge_current,
  output wire [3:0] precharge_current,
  output wire [3:0] termination_current,
  output wire [5:0] charge_voltage_limit,
  output wire precharge_to_fast_threshold,
  output wire recharge_offset
);
  reg rst_meta_q;
  reg rst_sync_q;
  reg [7:0] power_path_control_q;
  reg [7:0] charge_current_control_q;
  reg [7:0] precharge_termination_current_q;
  reg [7:0] charge_voltage_control_q;
  reg [31:0] tick_cnt_q;
  reg [31:0] wd_ms_q;
  reg [31:0] wd_limit;
  wire wd_fire;
  wire kick;
  wire [6:0] fast_charge_current_w;
  wire [5:0] charge_voltage_limit_w;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign kick = wr_en && (addr == `CCRB_OFS_POWER_PATH) &&
    wdata[`CCRB_BIT_KICK];
  assign fast_charge_current_w = (wdata[6:0] > `CCRB_FAST_CHARGE_CURRENT_MAX) ? `CCRB_FAST_CHARGE_CURRENT_MAX :
    wdata[6:0];
  assign charge_voltage_limit_w = (wdata[7:2] > `CCRB_CHARGE_VOLTAGE_LIMIT_MAX) ? `CCRB_CHARGE_VOLTAGE_LIMIT_MAX :
    wdata[7:2];

  // Watchdog period is a multiple of the 40 s unit; code zero disables it.
  always @* begin
    case (watchdog_period_sel)
      2'h1: wd_limit = WD_UNIT_MS;
      2'h2: wd_limit = WD_UNIT_MS * 2;
      2'h3: wd_limit = WD_UNIT_MS * 4;
      default: wd_limit = 32'h0;
    endcase
  end

  assign wd_fire = (wd_limit != 32'h0) && (wd_ms_q >= wd_limit - 32'h1) &&
    (tick_cnt_q == TICK_CYCLES - 1) && !kick;

  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tick_cnt_q <= 32'h0;
      wd_ms_q <= 32'h0;
      watchdog_expired <= 1'b0;
    end else begin
      watchdog_expired <= wd_fire;
      if (kick || reg_reset || wd_limit == 32'h0 || wd_fire) begin
        tick_cnt_q <= 32'h0;
        wd_ms_q <= 32'h0;
      end else if (tick_cnt_q == TICK_CYCLES - 1) begin
        tick_cnt_q <= 32'h0;
        wd_ms_q <= wd_ms_q + 32'h1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
    end
  end

  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      power_path_control_q <= `CCRB_RST_POWER_PATH;
      charge_current_control_q <= `CCRB_RST_CHG_CURRENT;
      precharge_termination_current_q <= `CCRB_RST_PRE_TERM;
      charge_voltage_control_q <= `CCRB_RST_CHG_VOLTAGE;
    end else if (reg_reset) begin
      power_path_control_q <= `CCRB_RST_POWER_PATH;
      charge_current_control_q <= `CCRB_RST_CHG_CURRENT;
      precharge_termination_current_q <= `CCRB_RST_PRE_TERM;
      charge_voltage_control_q <= `CCRB_RST_CHG_VOLTAGE;
    end else if (wd_fire) begin
      power_path_control_q <= {`CCRB_RST_POWER_PATH & 8'hF1} |
        {4'h0, power_path_control_q[3:1], 1'b0};
      charge_current_control_q <= `CCRB_RST_CHG_CURRENT;
      precharge_termination_current_q <= `CCRB_RST_PRE_TERM;
      charge_voltage_control_q <= `CCRB_RST_CHG_VOLTAGE;
    end else begin
      // The kick bit never stores; it reads back as zero.
      power_path_control_q[`CCRB_BIT_KICK] <= 1'b0;
      if (wr_en) begin
        case (addr)
          `CCRB_OFS_POWER_PATH: begin
            power_path_control_q <= wdata & 8'hBF;
          end
          `CCRB_OFS_CHG_CURRENT: begin
            charge_current_control_q <= {wdata[7], fast_charge_current_w};
          end
          `CCRB_OFS_PRE_TERM: begin
            precharge_termination_current_q <= wdata;
          end
          `CCRB_OFS_CHG_VOLTAGE: begin
            charge_voltage_control_q <= {charge_voltage_limit_w, wdata[1:0]};
          end
          default: begin
          end
        endcase
      end
    end
  end

  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata <= 8'h00;
    end else begin
      case (addr)
        `CCRB_OFS_POWER_PATH: rdata <= power_path_control_q;
        `CCRB_OFS_CHG_CURRENT: rdata <= charge_current_control_q;
        `CCRB_OFS_PRE_TERM: rdata <= precharge_termination_current_q;
        `CCRB_OFS_CHG_VOLTAGE: rdata <= charge_voltage_control_q;
        default: rdata <= 8'h00;
      endcase
    end
  end

  assign battery_load_enable = power_path_control_q[`CCRB_BIT_LOAD_EN];
  assign boost_output_enable = power_path_control_q[`CCRB_BIT_BOOST_EN];
  assign charge_enable = power_path_control_q[`CCRB_BIT_CHG_EN];
  assign min_system_voltage =
    power_path_control_q[`CCRB_SYSMIN_HI:`CCRB_SYSMIN_LO];
  assign boost_exit_select = power_path_control_q[`CCRB_BIT_BOOST_EXIT];
  assign pulse_control_enable =
    charge_current_control_q[`CCRB_BIT_PULSE_EN];
  assign fast_charge_current = charge_current_control_q[6:0];
  assign charge_active = charge_enable &&
    (fast_charge_current != 7'h00);
  assign precharge_current = precharge_termination_current_q[7:4];
  assign termination_current = precharge_termination_current_q[3:0];
  assign charge_voltage_limit = charge_voltage_control_q[7:2];
  assign precharge_to_fast_threshold =
    charge_voltage_control_q[`CCRB_BIT_PRE_FAST];
  assign recharge_offset = charge_voltage_control_q[`CCRB_BIT_RECHG];
endmodule // ccrb_register_bank

// ---- tb/ccrb_host.sv ----
// Host model for register access.
`timescale 1ns/1ps
module ccrb_host (input clk, input [7:0] rdata, output reg wr_en = 1'b0,
  output reg [7:0] addr = 8'h00, output reg [7:0] wdata = 8'h00);
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk) #1 {wr_en, addr, wdata} = {1'b1, a, d};
    @(posedge clk) #1 {wr_en, wdata} = {1'b0, ~d};
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clk) #1 addr = a;
    @(posedge clk) #1 d = rdata;
  endtask
endmodule // ccrb_host

// ---- tb/ccrb_assertions.sv ----
// Port assertions for the register bank.
`timescale 1ns/1ps
module ccrb_checker (input clk, rst_n, wr_en, reg_reset, watchdog_expired,
  input charge_enable, charge_active, input [7:0] addr, wdata, rdata,
  input [2:0] min_system_voltage, input [6:0] fast_charge_current,
  input [5:0] charge_voltage_limit);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(a); wr_en && addr == a && !reg_reset; endsequence
  a_fast_charge_current_clamp: assert property (s_wr(8'h04) ##0 wdata[6:0] > 7'h4F
    |=> fast_charge_current == 7'h4F) else $error("No current clamp.");
  a_charge_voltage_limit_clamp: assert property (s_wr(8'h06) ##0 wdata[7:2] > 6'h30
    |=> charge_voltage_limit == 6'h30) else $error("No voltage clamp.");
  a_active_gate: assert property (fast_charge_current == 7'h00 ||
    !charge_enable |-> !charge_active) else $error("Bad active flag.");
  a_kick_clear: assert property (addr == 8'h03 |=> !rdata[6])
    else $error("Kick bit stored.");
  a_unmapped_zero: assert property (addr < 8'h03 || addr > 8'h06
    |=> rdata == 8'h00) else $error("Unmapped read not zero.");
  a_wd_keep_min: assert property (watchdog_expired && !$past(wr_en)
    |-> $stable(min_system_voltage)) else $error("Min voltage lost.");
  a_wd_defaults: assert property (watchdog_expired |->
    fast_charge_current == 7'h20 && charge_voltage_limit == 6'h20)
    else $error("Bad watchdog defaults.");
  a_soft_reset: assert property (reg_reset |=>
    min_system_voltage == 3'h5 && fast_charge_current == 7'h20)
    else $error("Bad reset defaults.");
endmodule // ccrb_checker
bind ccrb_register_bank ccrb_checker chk_u (.clk, .rst_n, .wr_en, .reg_reset,
  .watchdog_expired, .charge_enable, .charge_active, .addr, .wdata, .rdata,
  .min_system_voltage, .fast_charge_current, .charge_voltage_limit);

// ---- tb/tb.sv ----
// Self-checking bench for the register bank.
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0, rst_n = 1'b0, reg_reset = 1'b0;
  reg [1:0] wd_sel = 2'h0;
  reg [7:0] v;
  wire wr_en, wd_exp, chg_act, load_en;
  wire [7:0] addr, wdata, rdata;
  integer n_errors = 0, n_tests = 0, i, n_exp = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (wd_exp === 1'b1) n_exp <= n_exp + 1;
  ccrb_host host_u (.clk, .rdata, .wr_en, .addr, .wdata);
  ccrb_register_bank #(.TICK_CYCLES(4), .WD_UNIT_MS(2)) dut_u (.clk, .rst_n,
    .wr_en, .addr, .wdata, .rdata, .reg_reset, .watchdog_period_sel(wd_sel),
    .watchdog_expired(wd_exp), .battery_load_enable(load_en),
    .boost_output_enable(),
    .charge_enable(), .charge_active(chg_act), .min_system_voltage(),
    .boost_exit_select(), .pulse_control_enable(), .fast_charge_current(),
    .precharge_current(), .termination_current(), .charge_voltage_limit(),
    .precharge_to_fast_threshold(), .recharge_offset());
  task close_out;
    $display("errors %0d of %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task rdchk(input [7:0] a, input [7:0] exp);
    host_u.rd(a, v);
    n_tests = n_tests + 1;
    if (v !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t reg %h read %h not %h", $time, a, v, exp);
    end
  endtask
  task t_defaults;
    rdchk(8'h03, 8'h3A);
    rdchk(8'h04, 8'h20);
    rdchk(8'h05, 8'h13);
    rdchk(8'h06, 8'h82);
  endtask
  task t_flag(input ok);
    n_tests = n_tests + 1;
    if (!ok) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t output flag wrong", $time);
    end
  endtask
  task t_clamp;
    host_u.wr(8'h04, 8'hFF);
    rdchk(8'h04, 8'hCF);
    host_u.wr(8'h06, 8'hFF);
    rdchk(8'h06, 8'hC3);
    host_u.wr(8'h04, 8'h00);
    t_flag(chg_act === 1'b0);
    host_u.wr(8'h03, 8'hFF);
    rdchk(8'h03, 8'hBF);
  endtask
  task t_kick;
    wd_sel = 2'h1;
    for (i = 0; i < 10; i = i + 1) host_u.wr(8'h03, 8'hCE);
    t_flag(n_exp == 0);
    t_flag(load_en === 1'b1);
    rdchk(8'h03, 8'h8E);
  endtask
  task t_watchdog;
    wd_sel = 2'h1;
    for (i = 0; i < 400 && wd_exp !== 1'b1; i = i + 1) #5;
    if (i == 400) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t watchdog never expired", $time);
      close_out;
    end
    rdchk(8'h03, 8'h3E);
    rdchk(8'h04, 8'h20);
    @(posedge clk) #1 reg_reset = 1'b1;
    @(posedge clk) #1 reg_reset = 1'b0;
    rdchk(8'h03, 8'h3A);
    t_flag(chg_act === 1'b1);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    t_defaults;
    t_clamp;
    t_kick;
    t_watchdog;
    close_out;
  end
endmodule // tb
